// ### design/ctwo_pkg.sv
// Constants for the transfer, test and wait instruction core.
// Assumes one core clock; each clock is one processor bus cycle.
package ctwo_pkg;
  // ---------------------------------------------------------------
  // Opcodes and cycle counts
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_FLAGS_TO_A = 8'h07;
  localparam logic [7:0] OP_TEST_A = 8'h4d;
  localparam logic [7:0] OP_TEST_B = 8'h5d;
  localparam logic [7:0] OP_TEST_EXT = 8'h7d;
  localparam logic [7:0] OP_TEST_IDX = 8'h6d;
  localparam logic [7:0] OP_SP_TO_IX = 8'h30;
  localparam logic [7:0] OP_IX_TO_SP = 8'h35;
  localparam logic [7:0] OP_SLEEP = 8'h3e;
  localparam logic [3:0] CYC_SHORT = 4'h2;
  localparam logic [3:0] CYC_XFER = 4'h3;
  localparam logic [3:0] CYC_MEM = 4'h6;
  localparam logic [3:0] CYC_SLEEP = 4'h9;
  localparam logic [3:0] CYC_PUSH_FIRST = 4'h3;
  localparam logic [3:0] CYC_OPND = 4'h4;
  // ---------------------------------------------------------------
  // Flag positions and reset values
  // ---------------------------------------------------------------
  localparam int FLG_H = 5;
  localparam int FLG_I = 4;
  localparam int FLG_N = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_V = 1;
  localparam int FLG_C = 0;
  localparam logic [5:0] RST_FLAGS = 6'h10;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h00ff;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam logic [4:0] OFS_ACC = 5'h08;
  localparam logic [4:0] OFS_IXSP = 5'h0c;
  localparam logic [4:0] OFS_PC = 5'h10;
  localparam int CTRL_RUN = 0;
  localparam logic RST_RUN = 1'b1;
  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_EXEC = 3'b001,
    ST_WAIT = 3'b010,
    ST_VEC_HI = 3'b011,
    ST_VEC_LO = 3'b100,
    ST_IDLE = 3'b101
  } ctwo_state_e;
endpackage

// ### design/ctwo_core.sv
// Processor core slice: flag copy, test, stack/index moves, sleep.
// Assumes async-read memory (data valid in the cycle of the address)
// and interrupt lines synchronous to core_clk.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ctwo_core
  import ctwo_pkg::*;
#(
  parameter logic [15:0] VEC_NMI = 16'hfff0, // Plain default
  parameter logic [15:0] VEC_MASKABLE_REQUEST_1 = 16'hfff2, // Plain default
  parameter logic [15:0] VEC_IRQ2 = 16'hfff4 // Plain default
) (
  input wire logic core_clk, // Bus cycle clock
  input wire logic srst, // Sync reset, high
  output logic [15:0] mem_addr, // Memory address
  output logic mem_rd, // Memory read
  output logic mem_wr, // Memory write
  output logic [7:0] mem_wdata, // Write data
  input wire logic [7:0] mem_rdata, // Read data, same cycle
  input wire logic nmi_n, // Nonmaskable request, low
  input wire logic maskable_request_1_n, // Maskable line 1, low
  input wire logic maskable_request_2_n, // Maskable line 2, low
  output logic wait_state, // Core is sleeping
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest // Stall
);
  import ctwo_pkg::*;

  ctwo_state_e st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] op_reg, op_next;
  logic [15:0] pc_reg, pc_next;
  logic [15:0] sp_reg, sp_next;
  logic [15:0] ix_reg, ix_next;
  logic [15:0] ea_reg, ea_next;
  logic [7:0] a_reg, a_next;
  logic [7:0] b_reg, b_next;
  logic [7:0] opnd_reg, opnd_next;
  logic [5:0] flags_reg, flags_next;
  logic [15:0] addr_next;
  logic rd_next, wr_next;
  logic [7:0] wdata_next;
  logic run_reg;
  logic wake;

  function automatic logic [5:0] test_flags(input logic [5:0] f,
                                            input logic [7:0] v);
    logic [5:0] r;
    r = f;
    r[FLG_N] = v[7];
    r[FLG_Z] = (v == 8'h00);
    r[FLG_V] = 1'b0;
    r[FLG_C] = 1'b0;
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  assign wake = !nmi_n || (!flags_reg[FLG_I] &&
    (!maskable_request_1_n || !maskable_request_2_n));

  always_comb begin
    logic fin;
    logic [3:0] idx;
    fin = 1'b0;
    idx = 4'h0;
    st_next = st_reg;
    cnt_next = cnt_reg + 4'h1;
    op_next = op_reg;
    pc_next = pc_reg;
    sp_next = sp_reg;
    ix_next = ix_reg;
    ea_next = ea_reg;
    a_next = a_reg;
    b_next = b_reg;
    opnd_next = opnd_reg;
    flags_next = flags_reg;
    case (st_reg)
      ST_FETCH: begin
        op_next = mem_rdata;
        pc_next = pc_reg + 16'h0001;
        cnt_next = CYC_SHORT;
        st_next = ST_EXEC;
      end
      ST_EXEC: begin
        case (op_reg)
          OP_FLAGS_TO_A: begin
            a_next = {2'b11, flags_reg};
            fin = 1'b1;
          end
          OP_TEST_A: begin
            flags_next = test_flags(flags_reg, a_reg);
            fin = 1'b1;
          end
          OP_TEST_B: begin
            flags_next = test_flags(flags_reg, b_reg);
            fin = 1'b1;
          end
          OP_TEST_EXT, OP_TEST_IDX: begin
            if (cnt_reg == CYC_SHORT) begin
              pc_next = pc_reg + 16'h0001;
              if (op_reg == OP_TEST_EXT) begin
                ea_next = {mem_rdata, 8'h00};
              end else begin
                ea_next = ix_reg + {8'h00, mem_rdata};
              end
            end
            if (cnt_reg == CYC_XFER && op_reg == OP_TEST_EXT) begin
              pc_next = pc_reg + 16'h0001;
              ea_next = {ea_reg[15:8], mem_rdata};
            end
            if (cnt_reg == CYC_OPND) begin
              opnd_next = mem_rdata;
            end
            if (cnt_reg == CYC_MEM) begin
              flags_next = test_flags(flags_reg, opnd_reg);
              fin = 1'b1;
            end
          end
          OP_SP_TO_IX: begin
            if (cnt_reg == CYC_XFER) begin
              ix_next = sp_reg + 16'h0001;
              fin = 1'b1;
            end
          end
          OP_IX_TO_SP: begin
            if (cnt_reg == CYC_XFER) begin
              sp_next = ix_reg - 16'h0001;
              fin = 1'b1;
            end
          end
          OP_SLEEP: begin
            if (cnt_reg >= CYC_PUSH_FIRST) begin
              sp_next = sp_reg - 16'h0001;
            end
            if (cnt_reg == CYC_SLEEP) begin
              st_next = ST_WAIT;
            end
          end
          default: fin = 1'b1;
        endcase
      end
      ST_WAIT: begin
        if (wake) begin
          flags_next[FLG_I] = 1'b1;
          st_next = ST_VEC_HI;
          if (!nmi_n) begin
            ea_next = VEC_NMI;
          end else if (!maskable_request_1_n) begin
            ea_next = VEC_MASKABLE_REQUEST_1;
          end else begin
            ea_next = VEC_IRQ2;
          end
        end
      end
      ST_VEC_HI: begin
        pc_next = {mem_rdata, pc_reg[7:0]};
        st_next = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        pc_next = {pc_reg[15:8], mem_rdata};
        fin = 1'b1;
      end
      ST_IDLE: begin
        if (run_reg) begin
          st_next = ST_FETCH;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    if (fin) begin
      st_next = run_reg ? ST_FETCH : ST_IDLE;
    end
    // Bus plan for the coming cycle
    rd_next = 1'b0;
    wr_next = 1'b0;
    addr_next = mem_addr;
    wdata_next = mem_wdata;
    if (st_next == ST_FETCH) begin
      rd_next = 1'b1;
      addr_next = pc_next;
    end else if (st_next == ST_VEC_HI) begin
      rd_next = 1'b1;
      addr_next = ea_next;
    end else if (st_next == ST_VEC_LO) begin
      rd_next = 1'b1;
      addr_next = ea_reg + 16'h0001;
    end else if (st_next == ST_EXEC) begin
      if ((op_next == OP_TEST_EXT || op_next == OP_TEST_IDX) &&
          (cnt_next == CYC_SHORT || cnt_next == CYC_OPND ||
           (cnt_next == CYC_XFER && op_next == OP_TEST_EXT))) begin
        rd_next = 1'b1;
        addr_next = (cnt_next == CYC_OPND) ? ea_next : pc_next;
      end
      if (op_next == OP_SLEEP && cnt_next >= CYC_PUSH_FIRST) begin
        wr_next = 1'b1;
        addr_next = sp_next;
        idx = cnt_next - CYC_PUSH_FIRST;
        case (idx)
          4'h0: wdata_next = pc_next[7:0];
          4'h1: wdata_next = pc_next[15:8];
          4'h2: wdata_next = ix_next[7:0];
          4'h3: wdata_next = ix_next[15:8];
          4'h4: wdata_next = a_next;
          4'h5: wdata_next = b_next;
          default: wdata_next = {2'b11, flags_next};
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Core state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= ST_FETCH;
      cnt_reg <= 4'h0;
      op_reg <= 8'h00;
      pc_reg <= RST_PC;
      sp_reg <= RST_SP;
      ix_reg <= 16'h0000;
      ea_reg <= 16'h0000;
      a_reg <= 8'h00;
      b_reg <= 8'h00;
      opnd_reg <= 8'h00;
      flags_reg <= RST_FLAGS;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      pc_reg <= pc_next;
      sp_reg <= sp_next;
      ix_reg <= ix_next;
      ea_reg <= ea_next;
      a_reg <= a_next;
      b_reg <= b_next;
      opnd_reg <= opnd_next;
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_addr <= RST_PC;
      mem_rd <= 1'b1;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      wait_state <= 1'b0;
    end else begin
      mem_addr <= addr_next;
      mem_rd <= rd_next;
      mem_wr <= wr_next;
      mem_wdata <= wdata_next;
      wait_state <= (st_next == ST_WAIT);
    end
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave, one wait cycle per access
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      run_reg <= RST_RUN;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          OFS_CTRL: avs_readdata <= {31'h0, run_reg};
          OFS_STAT: avs_readdata <= {21'h0, st_reg, 2'b11, flags_reg};
          OFS_ACC: avs_readdata <= {16'h0, b_reg, a_reg};
          OFS_IXSP: avs_readdata <= {sp_reg, ix_reg};
          OFS_PC: avs_readdata <= {16'h0, pc_reg};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL &&
          avs_byteenable[0]) begin
        run_reg <= avs_writedata[CTRL_RUN];
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  logic at_fetch;
  assign at_fetch = st_reg == ST_FETCH && run_reg;

  a_copy_flags_value: assert property (
    st_reg == ST_EXEC && op_reg == OP_FLAGS_TO_A |=>
      a_reg == {2'b11, $past(flags_reg)} && $stable(flags_reg))
    else $error("flag copy to A wrong");
  a_copy_flags_len: assert property (
    at_fetch && mem_rdata == OP_FLAGS_TO_A |->
      ##2 (st_reg == ST_FETCH || st_reg == ST_IDLE))
    else $error("flag copy length wrong");
  a_test_acc_flags: assert property (
    st_reg == ST_EXEC && op_reg == OP_TEST_A |=>
      flags_reg[FLG_N] == $past(a_reg[7]) &&
      flags_reg[FLG_Z] == ($past(a_reg) == 8'h00) &&
      !flags_reg[FLG_V] && !flags_reg[FLG_C] &&
      $stable(flags_reg[FLG_H]) && $stable(flags_reg[FLG_I]))
    else $error("test flags wrong");
  a_test_acc_len: assert property (
    at_fetch && (mem_rdata == OP_TEST_A || mem_rdata == OP_TEST_B) |->
      ##2 (st_reg == ST_FETCH || st_reg == ST_IDLE))
    else $error("test accumulator length wrong");
  a_test_mem_len: assert property (
    at_fetch && (mem_rdata == OP_TEST_EXT || mem_rdata == OP_TEST_IDX)
      |-> ##6 (st_reg == ST_FETCH || st_reg == ST_IDLE))
    else $error("test memory length wrong");
  a_stack_to_index: assert property (
    at_fetch && mem_rdata == OP_SP_TO_IX |->
      ##3 ix_reg == $past(sp_reg, 3) + 16'h0001 && $stable(sp_reg))
    else $error("stack to index wrong");
  a_index_to_stack: assert property (
    at_fetch && mem_rdata == OP_IX_TO_SP |->
      ##3 sp_reg == $past(ix_reg, 3) - 16'h0001 && $stable(ix_reg))
    else $error("index to stack wrong");
  a_push_order: assert property (
    st_reg == ST_EXEC && op_reg == OP_SLEEP &&
      cnt_reg >= CYC_PUSH_FIRST |->
      mem_wr && mem_addr == sp_reg)
    else $error("push not at stack pointer");
  a_push_flags: assert property (
    st_reg == ST_EXEC && op_reg == OP_SLEEP && cnt_reg == CYC_SLEEP
      |-> mem_wdata == {2'b11, flags_reg})
    else $error("stacked flags wrong");
  a_wait_hold: assert property (
    st_reg == ST_WAIT && !wake |=>
      st_reg == ST_WAIT && $stable(sp_reg) && !mem_rd && !mem_wr)
    else $error("wait state left or bus active");
  a_wake_vector: assert property (
    st_reg == ST_WAIT && !nmi_n |=>
      st_reg == ST_VEC_HI && flags_reg[FLG_I] && mem_rd &&
      mem_addr == VEC_NMI)
    else $error("wake vector wrong");
  a_sleep_flags: assert property (
    at_fetch && mem_rdata == OP_SLEEP |->
      ##9 st_reg == ST_WAIT && flags_reg == $past(flags_reg, 9))
    else $error("sleep length or flags wrong");

  c_copy_flags: cover property (
    st_reg == ST_EXEC && op_reg == OP_FLAGS_TO_A);
  c_test_mem: cover property (
    st_reg == ST_EXEC && op_reg == OP_TEST_IDX && cnt_reg == CYC_MEM);
  c_wake_nmi: cover property (st_reg == ST_WAIT && !nmi_n);
  c_wake_irq: cover property (
    st_reg == ST_WAIT && nmi_n && wake);
endmodule // ctwo_core
`default_nettype wire

// ### tb/ctwo_mem_model.sv
// Memory partner: async-read byte store, logs writes and first reads.
// Assumes one bus cycle per rising core_clk edge.
`timescale 1ns/1ps
`default_nettype none
module ctwo_mem_model (
  input wire logic core_clk, // Bus clock
  input wire logic srst, // Sync reset
  input wire logic [15:0] mem_addr, // Address
  input wire logic mem_rd, // Read strobe
  input wire logic mem_wr, // Write strobe
  input wire logic [7:0] mem_wdata, // Write data
  output logic [7:0] mem_rdata // Read data
);
  logic [7:0] mem [65536];
  int fst [65536];
  int cyc = 0;
  int nrd = 0;
  logic [7:0] last_reg = 8'h00;
  logic [15:0] wa [$];
  logic [7:0] wd [$];
  int wc [$];
  // Released bus shows inverse of last byte
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_reg;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (!srst && mem_rd) begin
      last_reg <= mem[mem_addr];
      nrd <= nrd + 1;
      if (fst[mem_addr] < 0) fst[mem_addr] <= cyc;
    end
    if (!srst && mem_wr) begin
      mem[mem_addr] <= mem_wdata;
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
      wc.push_back(cyc);
    end
  end
endmodule // ctwo_mem_model
`default_nettype wire

// ### tb/tb_top.sv
// Bench: short programs ending in sleep, stack and wake checks.
// Assumes the memory partner model and Avalon register access.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ctwo_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic nmi_n = 1'b1;
  logic maskable_request_1_n = 1'b1;
  logic maskable_request_2_n = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [15:0] mem_addr;
  logic mem_rd, mem_wr, wait_state, avs_waitrequest;
  logic [7:0] mem_wdata, mem_rdata;
  logic [31:0] avs_readdata, rd;
  int miscompares = 0;
  int compares = 0;
  // ---------------------------------------------------------------
  // Case table
  // ---------------------------------------------------------------
  localparam logic [39:0] PROG [6] = '{40'h073e000000, 40'h074d3e0000,
    40'h5d3e000000, 40'h7d00403e00, 40'h35303e0000, 40'h306d103e00};
  localparam int A3 [6] = '{1, 2, 1, 3, 2, 3};
  localparam int PRE [6] = '{2, 4, 2, 6, 6, 9};
  localparam logic [7:0] FL [6] = '{8'h10, 8'h18, 8'h14, 8'h18, 8'h10,
    8'h18};
  localparam logic [7:0] ACC [6] = '{8'hd0, 8'hd0, 8'h00, 8'h00, 8'h00,
    8'h00};
  localparam logic [15:0] IXV [6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h0100};
  localparam logic [15:0] SP0 [6] = '{16'h00ff, 16'h00ff, 16'h00ff,
    16'h00ff, 16'hffff, 16'h00ff};
  localparam logic [15:0] OA [6] = '{16'h0fff, 16'h0fff, 16'h0fff,
    16'h0040, 16'h0fff, 16'h0110};
  // ---------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------
  ctwo_core uut (.core_clk(core_clk), .srst(srst), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .nmi_n(nmi_n),
    .maskable_request_1_n(maskable_request_1_n),
    .maskable_request_2_n(maskable_request_2_n), .wait_state(wait_state),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  ctwo_mem_model m (.core_clk(core_clk), .srst(srst), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      miscompares++;
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic av_acc(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    tmo(n, 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic run_case(input int k);
    logic [15:0] pc;
    logic [15:0] sp;
    logic [55:0] st;
    int n;
    int f;
    srst <= 1'b1;
    nmi_n <= 1'b1;
    maskable_request_1_n <= 1'b1;
    maskable_request_2_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 65536; i++) begin
      m.mem[i] = 8'h00;
      m.fst[i] = -1;
    end
    m.wa.delete();
    m.wd.delete();
    m.wc.delete();
    m.mem[OA[k]] = 8'h80;
    m.mem[16'hfff0] = 8'h01;
    m.mem[16'hfff1] = 8'h23;
    m.mem[16'h0123] = 8'h01;
    for (int i = 0; i < 5; i++) m.mem[i] = PROG[k][39-8*i -: 8];
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    n = 0;
    while (wait_state !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    tmo(n, 300);
    f = m.fst[A3[k]];
    chk(m.cyc - f, 9);
    chk(f - m.fst[0], PRE[k]);
    pc = 16'(A3[k] + 1);
    sp = SP0[k];
    st = {pc[7:0], pc[15:8], IXV[k][7:0], IXV[k][15:8], ACC[k], 8'h00,
      2'b11, FL[k][5:0]};
    chk(m.wa.size(), 7);
    chk(m.wc[0] - f, 2);
    for (int i = 0; i < 7; i++) begin
      chk(m.wa[i], 16'(sp - i));
      chk(m.wd[i], st[55-8*i -: 8]);
    end
    // Masked lines must not wake the core while I is set
    @(posedge core_clk);
    maskable_request_1_n <= 1'b0;
    maskable_request_2_n <= 1'b0;
    n = m.nrd;
    repeat (20) @(posedge core_clk);
    #1;
    chk(wait_state, 1'b1);
    chk(m.nrd - n, 0);
    chk(m.wa.size(), 7);
    @(posedge core_clk);
    nmi_n <= 1'b0;
    n = 0;
    while (m.fst[16'h0123] < 0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    tmo(n, 50);
    chk(m.fst[16'hfff1] - m.fst[16'hfff0], 1);
    chk(m.fst[16'h0123] - m.fst[16'hfff1], 1);
    chk(wait_state, 1'b0);
    nmi_n <= 1'b1;
    maskable_request_1_n <= 1'b1;
    maskable_request_2_n <= 1'b1;
    av_acc(1'b0, OFS_ACC, 32'h0);
    chk(rd, {24'h0, ACC[k]});
    av_acc(1'b0, OFS_IXSP, 32'h0);
    chk(rd, {16'(sp - 7), IXV[k]});
    av_acc(1'b0, OFS_STAT, 32'h0);
    chk(rd[7:0], {2'b11, FL[k][5:0]});
    if (k == 0) begin
      av_acc(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h1);
      av_acc(1'b1, 5'h14, 32'hffffffff);
      av_acc(1'b0, 5'h14, 32'h0);
      chk(rd, 32'h0);
      av_acc(1'b1, OFS_CTRL, 32'h1);
    end
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    for (int k = 0; k < 6; k++) begin
      run_case(k);
    end
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
